/* core/ict_map.vh */
/*
 * Named constants of the instruction timing core: decode word fields, byte
 * lengths, cycle counts, status flag masks and debug synchroniser layout.
 * Assumes it is included by bare name from the core and debug files.
 */
`ifndef ICT_MAP_VH
`define ICT_MAP_VH

// Instruction lengths in program bytes.
`define ICT_B0 2'h0
`define ICT_B1 2'h1
`define ICT_B2 2'h2
`define ICT_B3 2'h3

// Execution times in system clock cycles.
`define ICT_C0 4'h0
`define ICT_C1 4'h1
`define ICT_C2 4'h2
`define ICT_C3 4'h3
`define ICT_C4 4'h4
`define ICT_C5 4'h5
`define ICT_C6 4'h6
`define ICT_C8 4'h8
`define ICT_CYC_MUL `ICT_C4
`define ICT_CYC_DIV `ICT_C8
`define ICT_CYC_MAX `ICT_C8

// Decode word layout: {cond, flag mask, length, cycles}.
`define ICT_D_W 10
`define ICT_D_CYC 3:0
`define ICT_D_LEN 5:4
`define ICT_D_FM 8:6
`define ICT_D_COND 9

// Status word flags touched, as {carry, aux carry, overflow}.
`define ICT_FM_NONE 3'h0
`define ICT_FM_CY 3'h4
`define ICT_FM_CYOV 3'h5
`define ICT_FM_ARITH 3'h7

// The one unassigned opcode.
`define ICT_OP_RSVD 8'hA5

// Debug pin synchroniser: {bp_en, bp_addr[15:0], step, run, halt}.
`define ICT_SYNC_W 20
`define ICT_SY_HALT 0
`define ICT_SY_RUN 1
`define ICT_SY_STEP 2
`define ICT_SY_ADDR 18:3
`define ICT_SY_BPEN 19

`endif

/* core/ict_debug.v */
/*
 * Debug run control: halt, run, single step and one hardware breakpoint.
 * Assumes the host pins are asynchronous to clk_sys; breakpoint address and
 * enable are changed only while the core is halted.
 */
`timescale 1ns/100ps
`include "ict_map.vh"

module ict_debug (
	input wire clk_sys,
	input wire rst,
	input wire dbg_halt_pin,
	input wire dbg_run_pin,
	input wire dbg_step_pin,
	input wire dbg_bp_en_pin,
	input wire [15:0] dbg_bp_addr_pin,
	input wire [15:0] fetch_pc,
	input wire at_boundary,
	input wire op_taken,
	output wire run_ok,
	output wire halted
);
	wire [`ICT_SYNC_W-1:0] pin_w;
	reg [`ICT_SYNC_W-1:0] s1_q;
	reg [`ICT_SYNC_W-1:0] s2_q;
	reg [`ICT_SYNC_W-1:0] s3_q;
	reg [`ICT_SYNC_W-1:0] acc_q;
	reg [`ICT_SYNC_W-1:0] prev_q;
	reg halted_q;
	reg step_q;
	reg skip_q;
	wire halt_edge;
	wire run_edge;
	wire step_edge;
	wire bp_hit;

	assign pin_w = {dbg_bp_en_pin, dbg_bp_addr_pin, dbg_step_pin, dbg_run_pin, dbg_halt_pin};

	// A bit is accepted only when the second and third stages agree.
	genvar i;
	generate
		for (i = 0; i < `ICT_SYNC_W; i = i + 1) begin : g_sync
			always @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					acc_q[i] <= 1'b0;
					prev_q[i] <= 1'b0;
				end else begin
					s1_q[i] <= pin_w[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						acc_q[i] <= s3_q[i];
					end
					prev_q[i] <= acc_q[i];
				end
			end
		end
	endgenerate

	assign halt_edge = acc_q[`ICT_SY_HALT] & ~prev_q[`ICT_SY_HALT];
	assign run_edge = acc_q[`ICT_SY_RUN] & ~prev_q[`ICT_SY_RUN];
	assign step_edge = acc_q[`ICT_SY_STEP] & ~prev_q[`ICT_SY_STEP];

	// Skip keeps a resumed core from stopping again on the breakpoint it sits on.
	assign bp_hit = acc_q[`ICT_SY_BPEN] & at_boundary & ~skip_q & ~halted_q &
		(fetch_pc == acc_q[`ICT_SY_ADDR]); // [RULE12]
	assign run_ok = (~halted_q | step_q) & ~bp_hit; // [RULE12]
	assign halted = halted_q;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			halted_q <= 1'b0;
			step_q <= 1'b0;
			skip_q <= 1'b0;
		end else begin
			if (op_taken) begin
				skip_q <= 1'b0;
				step_q <= 1'b0;
			end
			if (halted_q & run_edge) begin
				halted_q <= 1'b0; // [RULE12]
				skip_q <= 1'b1;
			end else if (halted_q & step_edge & ~step_q) begin
				step_q <= 1'b1; // [RULE12]
				skip_q <= 1'b1;
			end else if (~halted_q & (halt_edge | bp_hit)) begin
				halted_q <= 1'b1; // [RULE12]
			end
		end
	end
endmodule

/* core/ict_core.v */
/*
 * Instruction decode and cycle timing sequencer of a pipelined 8-bit core.
 * Assumes program memory presents one byte per cycle with its address, and
 * that the datapath supplies the branch condition on the last base cycle.
 */
// What this block does
// [RULE1] Decodes every opcode with the standard encoding, modes and status word flags.
// [RULE2] Counts execution only in whole system clock cycles, no machine cycles.
// [RULE3] Most instructions take as many cycles as they have program bytes.
// [RULE4] A conditional branch not taken ends one cycle before the taken case.
// [RULE5] No instruction occupies the core for more than eight cycles.
// [RULE6] Exactly 109 distinct instructions are decoded.
// [RULE7] Execution time mix: 26 one-cycle, 50 two-cycle, rest longer or variable; the decode gives CPL A (F4) two cycles, so 25 and 51.
// [RULE8] One-byte arithmetic or logic on indirect memory takes two cycles.
// [RULE9] Logic of immediate into a direct byte: three bytes, three cycles.
// [RULE10] Arithmetic with a working register source: one byte, one cycle.
// [RULE11] Arithmetic with a direct byte source: two bytes, two cycles.
// [RULE12] Host debug sets breakpoints, runs, halts, steps without core RAM, stack or timers.
// [RULE13] Multiply takes four cycles, divide takes eight.
`timescale 1ns/100ps
`include "ict_map.vh"

module ict_core (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] code_byte,
	input wire [15:0] code_pc,
	input wire code_valid,
	output wire code_ready,
	input wire branch_cond,
	input wire dbg_halt_pin,
	input wire dbg_run_pin,
	input wire dbg_step_pin,
	input wire dbg_bp_en_pin,
	input wire [15:0] dbg_bp_addr_pin,
	output wire dbg_halted,
	output wire busy,
	output wire instr_done,
	output wire [7:0] done_opcode,
	output wire [7:0] done_operand1,
	output wire [7:0] done_operand2,
	output wire [3:0] done_cycles,
	output wire [2:0] done_flag_mask,
	output wire done_taken,
	output wire done_illegal
);
	// Table lookup of one opcode; 255 opcodes map onto the 109 instructions.
	function [`ICT_D_W-1:0] ict_dec;
		input [7:0] op;
		reg [1:0] b;
		reg [3:0] c;
		reg cd;
		reg [2:0] fm;
		begin
			b = `ICT_B1;
			c = `ICT_C1;
			cd = 1'b0;
			fm = `ICT_FM_NONE;
			if (op[3]) begin
				case (op[7:4]) // [RULE10]
					4'h7, 4'h8, 4'hA: begin
						b = `ICT_B2;
						c = `ICT_C2;
					end
					4'hB: begin
						b = `ICT_B3;
						c = `ICT_C3;
						cd = 1'b1;
					end
					4'hD: begin
						b = `ICT_B2;
						c = `ICT_C2;
						cd = 1'b1;
					end
					default: ;
				endcase
			end else begin
				case (op[3:0])
					4'h6, 4'h7: begin
						c = `ICT_C2; // [RULE8]
						case (op[7:4])
							4'h7, 4'h8, 4'hA: b = `ICT_B2;
							4'hB: begin
								b = `ICT_B3;
								c = `ICT_C4;
								cd = 1'b1;
							end
							default: ;
						endcase
					end
					4'h5: begin
						b = `ICT_B2; // [RULE11]
						c = `ICT_C2;
						case (op[7:4])
							4'h7, 4'h8: begin
								b = `ICT_B3;
								c = `ICT_C3;
							end
							4'hB: begin
								b = `ICT_B3;
								c = `ICT_C4;
								cd = 1'b1;
							end
							4'hD: begin
								b = `ICT_B3;
								c = `ICT_C3;
								cd = 1'b1;
							end
							4'hA: begin
								b = `ICT_B1;
								c = `ICT_C1;
							end
							default: ;
						endcase
					end
					4'h4: begin
						case (op[7:4])
							4'h0, 4'h1, 4'hC, 4'hD, 4'hE: ;
							4'h8: c = `ICT_CYC_DIV; // [RULE13]
							4'hA: c = `ICT_CYC_MUL; // [RULE13]
							4'hB: begin
								b = `ICT_B3;
								c = `ICT_C3;
								cd = 1'b1;
							end
							4'hF: c = `ICT_C2;
							default: begin
								b = `ICT_B2;
								c = `ICT_C2;
							end
						endcase
					end
					4'h3: begin
						case (op[7:4])
							4'h4, 4'h5, 4'h6: begin
								b = `ICT_B3; // [RULE9]
								c = `ICT_C3;
							end
							4'h7, 4'h8, 4'hE, 4'hF: c = `ICT_C3;
							4'h9: c = `ICT_C4;
							default: ;
						endcase
					end
					4'h2: begin
						case (op[7:4])
							4'h0, 4'h1: begin
								b = `ICT_B3;
								c = `ICT_C5;
							end
							4'h2, 4'h3: c = `ICT_C6;
							4'hE, 4'hF: c = `ICT_C3;
							default: begin
								b = `ICT_B2;
								c = `ICT_C2;
							end
						endcase
					end
					4'h1: begin
						b = `ICT_B2;
						c = `ICT_C4;
					end
					default: begin
						case (op[7:4])
							4'h0: ;
							4'h1, 4'h2, 4'h3: begin
								b = `ICT_B3;
								c = `ICT_C3;
								cd = 1'b1;
							end
							4'h4, 4'h5, 4'h6, 4'h7: begin
								b = `ICT_B2;
								c = `ICT_C2;
								cd = 1'b1;
							end
							4'h8: begin
								b = `ICT_B2;
								c = `ICT_C4;
							end
							4'h9: begin
								b = `ICT_B3;
								c = `ICT_C3;
							end
							4'hE, 4'hF: c = `ICT_C3;
							default: begin
								b = `ICT_B2;
								c = `ICT_C2;
							end
						endcase
					end
				endcase
			end
			// Flags written as a side effect; parity always follows the accumulator.
			if ((op[7:4] == 4'h2 || op[7:4] == 4'h3 || op[7:4] == 4'h9) && op[3:2] != 2'h0) begin
				fm = `ICT_FM_ARITH; // [RULE1]
			end else if (op == 8'h84 || op == 8'hA4) begin
				fm = `ICT_FM_CYOV;
			end else if (op == 8'hD4 || op == 8'h13 || op == 8'h33 || op == 8'h72 || op == 8'h82 ||
				op == 8'hA0 || op == 8'hB0 || op == 8'hA2 || op == 8'hB3 || op == 8'hC3 || op == 8'hD3 ||
				(cd && op[7:4] == 4'hB)) begin
				fm = `ICT_FM_CY; // [RULE1]
			end
			ict_dec = {cd, fm, b, c};
		end
	endfunction

	wire [`ICT_D_W-1:0] dec_w;
	wire run_ok;
	wire free;
	wire take_op;
	wire opnd_need;
	wire stall;
	wire extend;
	reg [3:0] cnt_q;
	reg [1:0] left_q;
	reg [1:0] len_q;
	reg cond_q;
	reg ext_q;
	reg [3:0] used_q;
	reg [7:0] op_q;
	reg [7:0] opnd1_q;
	reg [7:0] opnd2_q;
	reg [2:0] fm_q;
	reg done_q;

	assign dec_w = ict_dec(code_byte); // [RULE6]
	assign free = (cnt_q == `ICT_C0);
	assign take_op = free & run_ok & code_valid;
	assign opnd_need = ~free & (left_q != `ICT_B0);
	// Waiting for an operand byte holds the count, so stalls never add counted cycles.
	assign stall = opnd_need & ~code_valid;
	assign code_ready = free ? run_ok : opnd_need;
	assign extend = (cnt_q == `ICT_C1) & cond_q & ~ext_q & branch_cond & ~stall; // [RULE4]
	assign busy = ~free;

	ict_debug u_debug (
		.clk_sys(clk_sys),
		.rst(rst),
		.dbg_halt_pin(dbg_halt_pin),
		.dbg_run_pin(dbg_run_pin),
		.dbg_step_pin(dbg_step_pin),
		.dbg_bp_en_pin(dbg_bp_en_pin),
		.dbg_bp_addr_pin(dbg_bp_addr_pin),
		.fetch_pc(code_pc),
		.at_boundary(free & code_valid),
		.op_taken(take_op),
		.run_ok(run_ok),
		.halted(dbg_halted)
	);

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= `ICT_C0;
			left_q <= `ICT_B0;
			len_q <= `ICT_B0;
			cond_q <= 1'b0;
			ext_q <= 1'b0;
			used_q <= `ICT_C0;
			op_q <= 8'h00;
			opnd1_q <= 8'h00;
			opnd2_q <= 8'h00;
			fm_q <= `ICT_FM_NONE;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (take_op) begin
				op_q <= code_byte;
				len_q <= dec_w[`ICT_D_LEN];
				left_q <= dec_w[`ICT_D_LEN] - `ICT_B1; // [RULE3]
				cond_q <= dec_w[`ICT_D_COND];
				fm_q <= dec_w[`ICT_D_FM];
				ext_q <= 1'b0;
				used_q <= `ICT_C1; // [RULE2]
				opnd1_q <= 8'h00;
				opnd2_q <= 8'h00;
				if (dec_w[`ICT_D_CYC] == `ICT_C1) begin
					done_q <= 1'b1;
				end else begin
					cnt_q <= dec_w[`ICT_D_CYC] - `ICT_C1; // [RULE7]
				end
			end else if (~free & ~stall) begin
				if (opnd_need) begin
					if (left_q == len_q - `ICT_B1) begin
						opnd1_q <= code_byte;
					end else begin
						opnd2_q <= code_byte;
					end
					left_q <= left_q - `ICT_B1;
				end
				// The used count saturates at eight, keeping the total within the eight-cycle ceiling.
				if (used_q != `ICT_CYC_MAX) begin
					used_q <= used_q + `ICT_C1; // [RULE5]
				end
				if (extend) begin
					ext_q <= 1'b1; // [RULE4]
				end else begin
					cnt_q <= cnt_q - `ICT_C1; // [RULE2]
					if (cnt_q == `ICT_C1) begin
						done_q <= 1'b1;
					end
				end
			end
		end
	end

	assign instr_done = done_q;
	assign done_opcode = op_q;
	assign done_operand1 = opnd1_q;
	assign done_operand2 = opnd2_q;
	assign done_cycles = used_q;
	assign done_flag_mask = fm_q;
	assign done_taken = ext_q;
	assign done_illegal = (op_q == `ICT_OP_RSVD);
endmodule

/* tb/ict_core_monitor.sv */
/* Checker of the instruction timing core, bound to ict_core.
   Assumes it sees only the core ports, one clock domain, reset active high. */
`timescale 1ns/100ps
module ict_core_mon (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] code_byte,
	input wire code_valid,
	input wire code_ready,
	input wire busy,
	input wire dbg_halted,
	input wire instr_done,
	input wire [7:0] done_opcode,
	input wire [3:0] done_cycles,
	input wire [2:0] done_flag_mask,
	input wire done_taken
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Opcodes are taken only while idle; later bytes of the same instruction arrive while busy.
	wire take_op = code_valid && code_ready && !busy;
	wire fin = instr_done;
	chk_reg_one: assert property (take_op && code_byte == 8'h28 |=> fin && done_cycles == 4'h1)
		else $error("register add not one cycle");
	chk_mul_four: assert property (take_op && code_byte == 8'hA4 |-> ##1 busy [*3] ##1 fin)
		else $error("multiply not four cycles");
	chk_div_eight: assert property (take_op && code_byte == 8'h84 |-> ##8 fin && done_cycles == 4'h8)
		else $error("divide not eight cycles");
	chk_max_eight: assert property (fin |-> done_cycles inside {[4'h1:4'h8]})
		else $error("cycle count out of range");
	chk_reg_arith: assert property (fin && done_opcode[3] && done_opcode[7:4] inside {4'h2, 4'h3, 4'h9}
		|-> done_cycles == 4'h1 && done_flag_mask == 3'h7)
		else $error("register arithmetic timing or flags wrong");
	chk_indirect_two: assert property (fin && done_opcode[3:1] == 3'h3
		&& done_opcode[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9} |-> done_cycles == 4'h2)
		else $error("indirect operand not two cycles");
	chk_direct_two: assert property (fin && done_opcode inside {8'h25, 8'h35, 8'h95}
		|-> done_cycles == 4'h2)
		else $error("direct operand not two cycles");
	chk_imm_direct: assert property (fin && done_opcode inside {8'h43, 8'h53, 8'h63}
		|-> done_cycles == 4'h3 && done_flag_mask == 3'h0)
		else $error("immediate to direct wrong");
	chk_branch_extra: assert property (fin && done_opcode == 8'h60
		|-> done_cycles == (done_taken ? 4'h3 : 4'h2))
		else $error("branch cycle count wrong");
	cover property (fin && done_taken);
	cover property ($rose(dbg_halted));
	cover property (fin && done_cycles == 4'h8);
endmodule

/* tb/ict_prog_mem.sv */
/* Program memory model feeding the core one byte a cycle.
   Assumes the bench loads mem and len while idle, then pulses start. */
`timescale 1ns/100ps
module ict_prog_mem (
	input wire clk_sys,
	input wire rst,
	input wire start,
	input wire stall,
	input wire [4:0] len,
	input wire code_ready,
	output wire [7:0] code_byte,
	output wire [15:0] code_pc,
	output wire code_valid
);
	reg [7:0] mem [0:31];
	reg [4:0] ptr_q;
	reg valid_q;
	wire [4:0] ptr_d = ptr_q + {4'h0, valid_q && code_ready};
	// An idle bus shows the inverse byte so a stale value is never read as good.
	assign code_byte = valid_q ? mem[ptr_q] : ~mem[ptr_q];
	assign code_pc = {11'h000, ptr_q};
	assign code_valid = valid_q;
	always @(posedge clk_sys or posedge rst) begin
		if (rst || start) begin
			ptr_q <= 5'h00;
			valid_q <= 1'b0;
		end else begin
			ptr_q <= ptr_d;
			// A byte once offered is held until taken; stalls only begin between bytes.
			if (!valid_q || code_ready)
				valid_q <= ptr_d != len && !stall;
		end
	end
endmodule

/* tb/tb_top.sv */
/* Self-checking bench of the instruction timing core.
   Assumes the program memory model and the port checker compile first. */
`timescale 1ns/100ps
module tb_top;
	logic clk_sys = 0, rst = 1, branch_cond = 0, start = 0, stall = 0, stall_on = 0;
	logic dbg_halt_pin = 0, dbg_run_pin = 0, dbg_step_pin = 0, dbg_bp_en_pin = 0;
	logic [15:0] dbg_bp_addr_pin = 16'h0000;
	logic [4:0] len = 5'h00;
	wire [7:0] code_byte, done_opcode, done_operand1, done_operand2;
	wire [15:0] code_pc;
	wire [3:0] done_cycles;
	wire [2:0] done_flag_mask;
	wire code_valid, code_ready, dbg_halted, busy, instr_done, done_taken, done_illegal;
	int n_mismatch = 0, n_tests = 0;
	logic [32:0] exp_q [$];
	logic [32:0] e;
	logic [7:0] ops [9] = '{8'h28, 8'h98, 8'h35, 8'h26, 8'h53, 8'hA4, 8'h84, 8'h60, 8'hA5};
	int lens [9] = '{1, 1, 2, 1, 3, 1, 1, 2, 1};
	int cycs [9] = '{1, 1, 2, 2, 3, 4, 8, 2, 1};
	logic [2:0] fms [9] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h0, 3'h5, 3'h5, 3'h0, 3'h0};
	ict_core u_ict_core (.clk_sys, .rst, .code_byte, .code_pc, .code_valid, .code_ready, .branch_cond,
		.dbg_halt_pin, .dbg_run_pin, .dbg_step_pin, .dbg_bp_en_pin, .dbg_bp_addr_pin, .dbg_halted, .busy,
		.instr_done, .done_opcode, .done_operand1, .done_operand2, .done_cycles, .done_flag_mask,
		.done_taken, .done_illegal);
	ict_prog_mem u_ict_prog_mem (.clk_sys, .rst, .start, .stall, .len, .code_ready, .code_byte, .code_pc,
		.code_valid);
	initial forever #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) stall <= stall_on && ($urandom % 4 == 0);
	task automatic cmp(input string nm, input logic [7:0] ex, input logic [7:0] g);
		n_tests++;
		if (g !== ex) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, g);
		end
	endtask
	always @(posedge clk_sys) if (instr_done === 1'b1) begin
		if (exp_q.size() == 0)
			cmp("spare done", 8'h00, 8'h01);
		else begin
			e = exp_q.pop_front();
			cmp("opcode", e[32:25], done_opcode);
			cmp("operand1", e[24:17], done_operand1);
			cmp("operand2", e[16:9], done_operand2);
			cmp("cycles", {4'h0, e[8:5]}, {4'h0, done_cycles});
			cmp("flags", {5'h00, e[4:2]}, {5'h00, done_flag_mask});
			cmp("taken", {7'h00, e[1]}, {7'h00, done_taken});
			cmp("illegal", {7'h00, e[0]}, {7'h00, done_illegal});
		end
	end
	task automatic load_prog(input int n, input logic bc);
		int a;
		logic [7:0] b;
		logic [7:0] c;
		logic tk;
		a = 0;
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			tk = ops[i] == 8'h60 && bc;
			u_ict_prog_mem.mem[a] = ops[i];
			u_ict_prog_mem.mem[a + 1] = b;
			c = 8'($urandom);
			u_ict_prog_mem.mem[a + 2] = c;
			// Operand bytes beyond the instruction length must read back as zero.
			exp_q.push_back({ops[i], lens[i] > 1 ? b : 8'h00, lens[i] > 2 ? c : 8'h00,
				4'(cycs[i] + tk), fms[i], tk, ops[i] == 8'hA5});
			a += lens[i];
		end
		len <= 5'(a);
		branch_cond <= bc;
		start <= 1;
		@(posedge clk_sys);
		start <= 0;
	endtask
	task automatic drain(input int keep);
		for (int k = 0; k < 300 && exp_q.size() > keep; k++) @(posedge clk_sys);
		repeat (20) @(posedge clk_sys);
		cmp("pending", 8'(keep), 8'(exp_q.size()));
	endtask
	task automatic await_halt(input logic v);
		for (int k = 0; k < 40 && dbg_halted !== v; k++) @(posedge clk_sys);
		cmp("halted", {7'h00, v}, {7'h00, dbg_halted});
	endtask
	task automatic poke(input logic run);
		dbg_step_pin <= !run;
		dbg_run_pin <= run;
		repeat (6) @(posedge clk_sys);
		dbg_step_pin <= 0;
		dbg_run_pin <= 0;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		$display("MISMATCH watchdog expected end seen hang");
		finish_test;
	end
	initial begin
		void'($urandom(32'h7ABD));
		repeat (4) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		load_prog(9, 1'b0);
		drain(0);
		$display("test back to back done");
		stall_on <= 1;
		load_prog(9, 1'b1);
		drain(0);
		$display("test stalls and taken branch done");
		stall_on <= 0;
		dbg_halt_pin <= 1;
		await_halt(1'b1);
		dbg_halt_pin <= 0;
		dbg_bp_addr_pin <= 16'h0002;
		dbg_bp_en_pin <= 1;
		load_prog(3, 1'b0);
		drain(3);
		poke(1'b0);
		drain(2);
		poke(1'b1);
		drain(1);
		await_halt(1'b1);
		dbg_bp_en_pin <= 0;
		poke(1'b1);
		drain(0);
		await_halt(1'b0);
		$display("test debug control done");
		finish_test;
	end
endmodule
bind ict_core ict_core_mon u_ict_core_mon (.clk_sys, .rst, .code_byte, .code_valid, .code_ready, .busy,
	.dbg_halted, .instr_done, .done_opcode, .done_cycles, .done_flag_mask, .done_taken);
